// File: core/clock_mode_map.vh
// Register offsets, field positions and constants for the channel clock mode selector
`ifndef CLOCK_MODE_MAP_VH
`define CLOCK_MODE_MAP_VH
`define ADDR_CHANNEL_CONFIG_0_LOW 4'h0
`define ADDR_GLOBAL_MODE_REG      4'h1
`define ADDR_BAUD_DIVISOR_LOW     4'h2
`define ADDR_BAUD_DIVISOR_HIGH    4'h3
`define ADDR_CLOCK_STATUS         4'h4
`define CFG_MODE_LSB              0
`define CFG_MODE_MSB              2
`define CFG_VARIANT_BIT           3
`define CFG_OVERSAMPLE_BIT        4
`define CFG_TX_OUT_EN_BIT         5
`define CFG_EXT_TRANSPARENT_BIT   6
`define GLOBAL_MODE_REG_XTAL_PD_BIT         0
`define CFG_RESET                 8'h00
`define GLOBAL_MODE_REG_RESET               8'h01
`define DIVISOR_RESET             16'h0000
`define OVERSAMPLE_DIV            16
`define MAJORITY_SAMPLES          3
`define MODE_0                    3'h0
`define MODE_1                    3'h1
`define MODE_2                    3'h2
`define MODE_3                    3'h3
`define MODE_4                    3'h4
`define MODE_5                    3'h5
`define MODE_6                    3'h6
`define MODE_7                    3'h7
`endif

// File: core/clock_mode_select.v
// Per-channel clock source selection with baud divider and phase recovery loop
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "clock_mode_map.vh"

// Overview of operation
// R1 - Mode field plus variant bit select the clocking configuration, a or b.
// R2 - Oversample bit divides receive, and both in modes 1, 3b, 7b, by sixteen.
// R3 - With oversampling the receiver takes three samples and votes by majority.
// R4 - Oversample bit ignored in modes 2, 3a, 4, 5, 6, 7a.
// R5 - Software clears crystal power down when using modes 0b, 6 or 7.
// R6 - Crystal source may feed either channel; each has own divider and loop.
// R7 - Crystal input alone accepts an external clock.
// R8 - Transmit-clock-out enable drives transmit clock pin in allowed modes.
// R9 - Mode 6b: transmit from divider/16 on crystal; receive from loop.
// R10 - Loop output equals its reference divided by sixteen.
// R11 - Mode 0: receive from pin; transmit from pin (0a) or divider (0b).
// R12 - Mode 0b drives generated transmit clock out when enabled.
// R13 - Mode 1: both clocks from receive pin; strobes from carrier and tx pin.
// R14 - Mode 1 bits move only when the matching strobe is asserted.
// R15 - Extended transparent: one strobe moves a whole byte.
// R16 - Mode 2: divider from receive pin feeds loop; loop clocks receive.
// R17 - Mode 2a transmit from pin; 2b from divider/16, may be driven out.
// R18 - Modes 3,6,7 source mapping for loop, divider and pins.
// R19 - Mode 4 transfers bits only while the respective gate allows.
// R20 - Mode 5a common receive pin clock with frame sync; 5b separate octet syncs.
// R21 - Mode 5a with out enable drives time-slot window, low when active.
// R22 - Loop always sourced from own divider programmed by two divisor registers.
// R23 - Timers run on the transmit domain clock in every mode.
// R24 - Mode changes switch domain clocks without runt pulses.
module clock_mode_select #(
    parameter DIV_W = 16
) (
    input  wire        i_mclk,
    input  wire        i_rst,
    input  wire [3:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    input  wire        i_rx_clock_pin,
    input  wire        i_tx_clock_pin,
    output reg         o_tx_clock_pin,
    output reg         o_tx_clock_pin_oe_n,
    input  wire        i_crystal_in,
    input  wire        i_carrier_detect_in,
    input  wire        i_rx_gate_in,
    input  wire        i_tx_gate_in,
    input  wire        i_frame_sync_in,
    input  wire        i_tx_octet_sync_in,
    input  wire        i_rx_octet_sync_in,
    input  wire        i_rx_slot_window,
    input  wire        i_tx_slot_window,
    input  wire        i_rx_data,
    output reg         o_rx_tick,
    output reg         o_rx_bit,
    output reg         o_tx_tick,
    output reg         o_timer_tick,
    output reg         o_rx_sync,
    output reg         o_tx_sync,
    output reg         o_crystal_power_down
);

    reg  [7:0]       cfg;
    reg  [7:0]       global_mode_reg;
    reg  [DIV_W-1:0] divisor;
    reg  [2:0]       mode_act;
    reg              var_act;
    reg              pending;

    // Pin synchronisers, first stage read only by the second
    reg  [8:0] sync1;
    reg  [8:0] sync2;
    reg  [8:0] prev;
    wire [8:0] pins = {i_rx_data, i_rx_octet_sync_in, i_tx_octet_sync_in, i_frame_sync_in,
                       i_tx_gate_in, i_rx_gate_in, i_carrier_detect_in, i_tx_clock_pin,
                       i_rx_clock_pin};
    wire       rxp_rise  = sync2[0] & ~prev[0];
    wire       txp_rise  = sync2[1] & ~prev[1];
    wire       xtal_rise;
    reg        xtal_s1;
    reg        xtal_s2;
    reg        xtal_prev;

    always @(posedge i_mclk) begin
        if (i_rst) begin
            sync1     <= 9'h000;
            sync2     <= 9'h000;
            prev      <= 9'h000;
            xtal_s1   <= 1'b0;
            xtal_s2   <= 1'b0;
            xtal_prev <= 1'b0;
        end else begin
            sync1     <= pins;
            sync2     <= sync1;
            prev      <= sync2;
            xtal_s1   <= i_crystal_in; // R7
            xtal_s2   <= xtal_s1;
            xtal_prev <= xtal_s2;
        end
    end
    // Power-down masks the crystal; driver stays outside this block
    assign xtal_rise = xtal_s2 & ~xtal_prev & ~global_mode_reg[`GLOBAL_MODE_REG_XTAL_PD_BIT]; // R5

    // Register port
    always @(posedge i_mclk) begin
        if (i_rst) begin
            cfg     <= `CFG_RESET;
            global_mode_reg   <= `GLOBAL_MODE_REG_RESET;
            divisor <= `DIVISOR_RESET;
            o_rdata <= 8'h00;
        end else begin
            if (i_wr) begin
                case (i_addr)
                    `ADDR_CHANNEL_CONFIG_0_LOW: cfg <= i_wdata;
                    `ADDR_GLOBAL_MODE_REG:      global_mode_reg <= i_wdata;
                    `ADDR_BAUD_DIVISOR_LOW:     divisor[7:0] <= i_wdata; // R22
                    `ADDR_BAUD_DIVISOR_HIGH:    divisor[DIV_W-1:8] <= i_wdata[DIV_W-9:0];
                    default: ;
                endcase
            end
            o_rdata <= 8'h00;
            if (i_rd) begin
                case (i_addr)
                    `ADDR_CHANNEL_CONFIG_0_LOW: o_rdata <= cfg;
                    `ADDR_GLOBAL_MODE_REG:      o_rdata <= global_mode_reg;
                    `ADDR_BAUD_DIVISOR_LOW:     o_rdata <= divisor[7:0];
                    `ADDR_BAUD_DIVISOR_HIGH:    o_rdata <= divisor[DIV_W-1:8];
                    `ADDR_CLOCK_STATUS:         o_rdata <= {3'b000, pending, var_act, mode_act};
                    default:                    o_rdata <= 8'h00;
                endcase
            end
        end
    end

    wire [2:0] mode_req = cfg[`CFG_MODE_MSB:`CFG_MODE_LSB];
    wire       var_req  = cfg[`CFG_VARIANT_BIT];                     // R1
    wire       tx_oe    = cfg[`CFG_TX_OUT_EN_BIT];
    wire       etm      = cfg[`CFG_EXT_TRANSPARENT_BIT];

    // Baud divider: source picked by active mode
    reg              brg_src;
    reg  [DIV_W-1:0] brg_cnt;
    reg              brg_tick;
    always @* begin
        case (mode_act)
            `MODE_0, `MODE_6, `MODE_7: brg_src = xtal_rise;          // R9 R11 R18
            `MODE_2, `MODE_3:          brg_src = rxp_rise;           // R16 R18
            default:                   brg_src = 1'b0;
        endcase
    end
    always @(posedge i_mclk) begin
        if (i_rst) begin
            brg_cnt  <= {DIV_W{1'b0}};
            brg_tick <= 1'b0;
        end else begin
            brg_tick <= 1'b0;
            if (brg_src) begin
                if (brg_cnt >= divisor) begin
                    brg_cnt  <= {DIV_W{1'b0}};
                    brg_tick <= 1'b1;
                end else begin
                    brg_cnt <= brg_cnt + 1'b1;
                end
            end
        end
    end

    // Phase recovery loop: reference /16, realigned on data edges
    reg [3:0] pll_cnt;
    reg       pll_tick;
    wire      data_edge = sync2[8] ^ prev[8];
    always @(posedge i_mclk) begin
        if (i_rst) begin
            pll_cnt  <= 4'h0;
            pll_tick <= 1'b0;
        end else begin
            pll_tick <= 1'b0;
            if (data_edge) begin
                pll_cnt <= 4'h8;
            end else if (brg_tick) begin                              // R22
                pll_cnt <= pll_cnt + 4'h1;
                if (pll_cnt == 4'hF)
                    pll_tick <= 1'b1;                                 // R10
            end
        end
    end

    // Divide by sixteen of the divider output for 2b and 6b
    reg [3:0] b16_cnt;
    reg       b16_tick;
    always @(posedge i_mclk) begin
        if (i_rst) begin
            b16_cnt  <= 4'h0;
            b16_tick <= 1'b0;
        end else begin
            b16_tick <= brg_tick && b16_cnt == 4'hF;
            if (brg_tick)
                b16_cnt <= b16_cnt + 4'h1;
        end
    end

    // Raw domain tick sources
    reg raw_rx;
    reg raw_tx;
    reg os_rx;
    reg os_tx;
    always @* begin
        raw_rx = 1'b0;
        raw_tx = 1'b0;
        os_rx  = 1'b0;
        os_tx  = 1'b0;
        case (mode_act)
            `MODE_0: begin
                raw_rx = rxp_rise;
                raw_tx = var_act ? brg_tick : txp_rise;               // R11
                os_rx  = 1'b1;                                        // R2
            end
            `MODE_1: begin
                raw_rx = rxp_rise;
                raw_tx = rxp_rise;                                    // R13
                os_rx  = 1'b1;
                os_tx  = 1'b1;
            end
            `MODE_2: begin
                raw_rx = pll_tick;                                    // R16
                raw_tx = var_act ? b16_tick : txp_rise;               // R17
            end
            `MODE_3, `MODE_7: begin
                raw_rx = var_act ? brg_tick : pll_tick;               // R18
                raw_tx = var_act ? brg_tick : pll_tick;
                os_rx  = var_act;
                os_tx  = var_act;                                     // R4
            end
            `MODE_4: begin
                raw_rx = rxp_rise;
                raw_tx = txp_rise;
            end
            `MODE_5: begin
                raw_rx = rxp_rise;
                raw_tx = var_act ? txp_rise : rxp_rise;               // R20
            end
            `MODE_6: begin
                raw_rx = pll_tick;                                    // R9
                raw_tx = var_act ? b16_tick : txp_rise;
            end
            default: ;
        endcase
    end

    // Oversampling /16 with three-sample majority
    wire       ovs = cfg[`CFG_OVERSAMPLE_BIT];
    reg  [3:0] rx_div;
    reg  [3:0] tx_div;
    reg  [2:0] votes;
    wire       rx_div_tick = raw_rx && rx_div == 4'hF;
    wire       tx_div_tick = raw_tx && tx_div == 4'hF;
    wire       eff_rx = (ovs && os_rx) ? rx_div_tick : raw_rx;       // R2 R4
    wire       eff_tx = (ovs && os_tx) ? tx_div_tick : raw_tx;
    wire       maj    = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);
    always @(posedge i_mclk) begin
        if (i_rst) begin
            rx_div <= 4'h0;
            tx_div <= 4'h0;
            votes  <= 3'b000;
        end else begin
            if (raw_rx)
                rx_div <= rx_div + 4'h1;
            if (raw_tx)
                tx_div <= tx_div + 4'h1;
            // Mid-bit samples 7, 8 and 9
            if (raw_rx && rx_div >= 4'h7 && rx_div <= 4'h9)
                votes <= {votes[1:0], sync2[8]};                      // R3
        end
    end

    // Bit qualification: strobes, gates, slot windows
    reg [2:0] rx_bits;
    reg [2:0] tx_bits;
    reg       rx_q;
    reg       tx_q;
    always @* begin
        rx_q = 1'b1;
        tx_q = 1'b1;
        case (mode_act)
            `MODE_1: begin
                rx_q = sync2[2] | (etm & rx_bits != 3'h0);            // R14 R15
                tx_q = sync2[1] | (etm & tx_bits != 3'h0);
            end
            `MODE_4: begin
                rx_q = sync2[3];                                      // R19
                tx_q = sync2[4];
            end
            `MODE_5: begin
                rx_q = i_rx_slot_window;
                tx_q = i_tx_slot_window;
            end
            default: ;
        endcase
    end
    always @(posedge i_mclk) begin
        if (i_rst) begin
            rx_bits <= 3'h0;
            tx_bits <= 3'h0;
        end else if (!etm || mode_act != `MODE_1) begin
            // Stale counts from another mode would pass unstrobed bits
            rx_bits <= 3'h0;
            tx_bits <= 3'h0;
        end else begin
            // One strobe starts a byte of eight bits
            if (eff_rx && rx_q)
                rx_bits <= rx_bits + 3'h1;
            if (eff_tx && tx_q)
                tx_bits <= tx_bits + 3'h1;
        end
    end

    // Mode switch only at a quiet point of both domains, avoiding runts
    always @(posedge i_mclk) begin
        if (i_rst) begin
            mode_act <= `MODE_0;
            var_act  <= 1'b0;
            pending  <= 1'b0;
        end else begin
            pending <= (mode_req != mode_act) || (var_req != var_act);
            if (((mode_req != mode_act) || (var_req != var_act)) && !eff_rx && !eff_tx) begin
                mode_act <= mode_req;                                 // R24
                var_act  <= var_req;
            end
        end
    end

    // Domain outputs and pin drive
    wire sync_rx = (mode_act == `MODE_5) ? (var_act ? sync2[7] : sync2[5]) : 1'b0;
    wire sync_tx = (mode_act == `MODE_5) ? (var_act ? sync2[6] : sync2[5]) : 1'b0;
    reg  out_ok;
    always @* begin
        case (mode_act)
            `MODE_0: out_ok = var_act;                                // R12
            `MODE_2, `MODE_6: out_ok = var_act;                       // R17
            `MODE_3, `MODE_7: out_ok = 1'b1;
            `MODE_5: out_ok = ~var_act;                               // R21
            default: out_ok = 1'b0;
        endcase
    end
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_rx_tick            <= 1'b0;
            o_rx_bit             <= 1'b0;
            o_tx_tick            <= 1'b0;
            o_timer_tick         <= 1'b0;
            o_rx_sync            <= 1'b0;
            o_tx_sync            <= 1'b0;
            o_tx_clock_pin       <= 1'b1;
            o_tx_clock_pin_oe_n  <= 1'b1;
            o_crystal_power_down <= 1'b1;
        end else begin
            o_rx_tick            <= eff_rx & rx_q;
            o_rx_bit             <= (ovs && os_rx) ? maj : sync2[8];  // R3
            o_tx_tick            <= eff_tx & tx_q;
            o_timer_tick         <= eff_tx;                           // R23
            o_rx_sync            <= sync_rx;                          // R20
            o_tx_sync            <= sync_tx;
            o_crystal_power_down <= global_mode_reg[`GLOBAL_MODE_REG_XTAL_PD_BIT];        // R6
            o_tx_clock_pin_oe_n  <= ~(tx_oe & out_ok);                // R8
            if (mode_act == `MODE_5)
                o_tx_clock_pin <= ~i_tx_slot_window;                  // R21
            else if (eff_tx)
                o_tx_clock_pin <= ~o_tx_clock_pin;
        end
    end

endmodule // clock_mode_select

// File: sim/serial_clock_monitor.sv
// Assertion checker for the channel clock mode selector ports
`timescale 1ns/10ps
module serial_clock_monitor (
    input wire       i_mclk,
    input wire       i_rst,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire       i_wr,
    input wire       i_rd,
    input wire [7:0] o_rdata,
    input wire       i_tx_slot_window,
    input wire       o_tx_clock_pin,
    input wire       o_tx_clock_pin_oe_n,
    input wire       o_rx_tick,
    input wire       o_tx_tick,
    input wire       o_timer_tick,
    input wire       o_crystal_power_down
);
    // Modes 0b 2b 3a 3b 5a 6b 7a 7b, indexed by {mode, variant}
    localparam logic [15:0] OUT_MODES = 16'he4e2;
    logic [7:0] cfg_q;
    logic       out_ok;
    logic       slot_out;

    always @(posedge i_mclk) begin
        if (i_rst) begin
            cfg_q <= 8'h00;
        end else if (i_wr && i_addr == 4'h0) begin
            cfg_q <= i_wdata;
        end
    end
    assign out_ok   = cfg_q[5] && OUT_MODES[{cfg_q[2:0], cfg_q[3]}];
    assign slot_out = cfg_q[5] && cfg_q[3:0] == 4'h5;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    a_unmapped_zero: assert property (i_rd && i_addr > 4'h4 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_cfg_readback: assert property (i_rd && i_addr == 4'h0 |=> o_rdata[6:0] == cfg_q[6:0])
        else $error("config readback wrong");
    a_xtal_pd_write: assert property (i_wr && i_addr == 4'h1
        |=> ##1 o_crystal_power_down == $past(i_wdata[0], 2))
        else $error("crystal power down not written");
    a_rx_tick_single: assert property (o_rx_tick |=> !o_rx_tick)
        else $error("receive tick longer than one cycle");
    a_tx_tick_timer: assert property (o_tx_tick |-> o_timer_tick)
        else $error("qualified transmit tick without timer tick");
    a_oe_allowed: assert property (!o_tx_clock_pin_oe_n
        |-> out_ok || $past(out_ok) || $past(out_ok, 2))
        else $error("transmit pin driven in a mode without output");
    a_oe_released: assert property (!out_ok && !$past(out_ok) && !$past(out_ok, 2)
        |-> o_tx_clock_pin_oe_n)
        else $error("transmit pin not released");
    a_slot_window: assert property (slot_out && $past(slot_out, 3)
        |-> o_tx_clock_pin == !$past(i_tx_slot_window))
        else $error("slot window output wrong");
endmodule // serial_clock_monitor

bind clock_mode_select serial_clock_monitor i_mon (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_slot_window(i_tx_slot_window),
    .o_tx_clock_pin(o_tx_clock_pin), .o_tx_clock_pin_oe_n(o_tx_clock_pin_oe_n),
    .o_rx_tick(o_rx_tick), .o_tx_tick(o_tx_tick), .o_timer_tick(o_timer_tick),
    .o_crystal_power_down(o_crystal_power_down));

// File: sim/serial_line_model.sv
// Line equipment model: pin clocks, crystal, strobes, gates and data
`timescale 1ns/10ps
module serial_line_model (
    input  wire  i_mclk,
    output logic o_rx_clock_pin,
    output logic o_tx_clock_pin,
    output logic o_crystal_in,
    output logic o_carrier_detect_in,
    output logic o_rx_gate_in,
    output logic o_tx_gate_in,
    output logic o_rx_data
);
    int n_rise = 0;
    int n_rxq  = 0;
    int n_txq  = 0;
    bit rx_s[$];
    bit tx_s[$];
    bit d_s[$];

    initial begin
        {o_rx_clock_pin, o_tx_clock_pin, o_crystal_in} = 3'h0;
        {o_carrier_detect_in, o_rx_gate_in, o_tx_gate_in, o_rx_data} = 4'h0;
    end

    // Strobes change in the low half, so they are settled long before the
    // rising edge they qualify; clocks stand low between bursts
    task automatic burst(input int n, input bit tx_strobe);
        logic s_r;
        logic s_t;
        logic s_d;
        n_rise = 0;
        n_rxq = 0;
        n_txq = 0;
        rx_s = {};
        tx_s = {};
        d_s = {};
        for (int i = 0; i < n; i++) begin
            s_r = 1'($urandom);
            s_t = 1'($urandom);
            s_d = 1'($urandom);
            @(posedge i_mclk);
            o_rx_clock_pin <= 1'b0;
            o_crystal_in <= 1'b0;
            o_tx_clock_pin <= tx_strobe & s_t;
            o_carrier_detect_in <= s_r;
            o_rx_gate_in <= s_r;
            o_tx_gate_in <= s_t;
            o_rx_data <= s_d;
            repeat (3) @(posedge i_mclk);
            o_rx_clock_pin <= 1'b1;
            o_crystal_in <= 1'b1;
            o_tx_clock_pin <= tx_strobe ? s_t : 1'b1;
            n_rise++;
            n_rxq += s_r;
            n_txq += s_t;
            rx_s.push_back(s_r);
            tx_s.push_back(s_t);
            d_s.push_back(s_d);
            repeat (2) @(posedge i_mclk);
        end
        @(posedge i_mclk);
        {o_rx_clock_pin, o_crystal_in, o_tx_clock_pin} <= 3'h0;
        {o_carrier_detect_in, o_rx_gate_in, o_tx_gate_in} <= {!s_r, !s_r, !s_t};
        o_rx_data <= !o_rx_data;
    endtask
endmodule // serial_line_model

// File: sim/tb_top.sv
// Self-checking bench for the channel clock mode selector
`timescale 1ns/10ps
module tb_top;
    localparam int DIV = 3;
    localparam logic [7:0] MODES [12] = '{8'h20, 8'h10, 8'h28, 8'h01, 8'h41, 8'h14, 8'h0a,
                                          8'h0b, 8'h1b, 8'h0f, 8'h0e, 8'h25};
    logic       i_mclk = 1'b0;
    logic       i_rst = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic       i_tx_slot_window = 1'b1;
    logic       pin_q = 1'b1;
    logic       fsync = 1'b0;
    wire        o_rx_bit, o_rx_sync, o_tx_sync;
    wire  [7:0] o_rdata;
    wire        o_tx_clock_pin, o_tx_clock_pin_oe_n, o_rx_tick, o_tx_tick, o_timer_tick;
    wire        o_crystal_power_down, rx_pin, tx_pin, xtal, cd, rx_gate, tx_gate, rx_data;
    int         err_total = 0;
    int         checks = 0;
    int         cycles = 0;
    int         rx_cnt, tx_cnt, tm_cnt, tg_cnt;

    always #50 i_mclk = ~i_mclk;

    serial_line_model i_serial_line_model (.i_mclk(i_mclk), .o_rx_clock_pin(rx_pin),
        .o_tx_clock_pin(tx_pin), .o_crystal_in(xtal), .o_carrier_detect_in(cd),
        .o_rx_gate_in(rx_gate), .o_tx_gate_in(tx_gate), .o_rx_data(rx_data));

    clock_mode_select i_clock_mode_select (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_rx_clock_pin(rx_pin), .i_tx_clock_pin(tx_pin), .o_tx_clock_pin(o_tx_clock_pin),
        .o_tx_clock_pin_oe_n(o_tx_clock_pin_oe_n), .i_crystal_in(xtal),
        .i_carrier_detect_in(cd), .i_rx_gate_in(rx_gate), .i_tx_gate_in(tx_gate),
        .i_frame_sync_in(fsync), .i_tx_octet_sync_in(1'b0), .i_rx_octet_sync_in(1'b0),
        .i_rx_slot_window(1'b1), .i_tx_slot_window(i_tx_slot_window), .i_rx_data(rx_data),
        .o_rx_tick(o_rx_tick), .o_rx_bit(o_rx_bit), .o_tx_tick(o_tx_tick),
        .o_timer_tick(o_timer_tick), .o_rx_sync(o_rx_sync), .o_tx_sync(o_tx_sync),
        .o_crystal_power_down(o_crystal_power_down));

    task automatic give_verdict();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Counters are cleared on the falling edge to stay clear of this block
    always @(posedge i_mclk) begin
        cycles++;
        rx_cnt += o_rx_tick;
        tx_cnt += o_tx_tick;
        tm_cnt += o_timer_tick;
        tg_cnt += (pin_q !== o_tx_clock_pin);
        pin_q = o_tx_clock_pin;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        check(o_rdata, exp);
    endtask

    // Strobed byte mode: a strobe opens a byte, the rest of it needs none
    function automatic int etm_count(input bit s[$]);
        int b = 0;
        int cnt = 0;
        foreach (s[i]) begin
            if (s[i] || b != 0) begin
                cnt++;
                b = (b + 1) % 8;
            end
        end
        return cnt;
    endfunction

    initial begin
        logic [7:0] c;
        int n, e_rx, e_tx, e_tm, vote;
        void'($urandom(32'h25ea_c79a));
        repeat (3) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(negedge i_mclk);
        check({o_tx_clock_pin, o_tx_clock_pin_oe_n, o_crystal_power_down}, 3'h7);
        rd_check(4'h1, 8'h01);
        rd_check(4'h0, 8'h00);
        rd_check(4'h3, 8'h00);
        wr(4'h9, 8'hff);
        rd_check(4'h9, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h2, 8'(DIV));
        wr(4'h3, 8'h00);
        rd_check(4'h2, 8'(DIV));
        check(o_crystal_power_down, 1'b0);
        foreach (MODES[k]) begin
            c = MODES[k];
            wr(4'h0, c);
            rd_check(4'h0, c);
            repeat (4) @(posedge i_mclk);
            @(negedge i_mclk);
            {rx_cnt, tx_cnt, tm_cnt, tg_cnt} = '0;
            i_serial_line_model.burst(64, c[2:0] == 3'h1);
            repeat (10) @(posedge i_mclk);
            @(negedge i_mclk);
            n = i_serial_line_model.n_rise;
            {e_rx, e_tx} = {n, n};
            case ({c[2:0], c[3]})
                4'h0: e_rx = c[4] ? n / 16 : n;
                4'h1: e_tx = n / (DIV + 1);
                4'h2, 4'h8: {e_rx, e_tx} = {i_serial_line_model.n_rxq, i_serial_line_model.n_txq};
                4'h5, 4'hd: {e_rx, e_tx} = {32'hffff_ffff, n / ((DIV + 1) * 16)};
                4'h7, 4'hf: {e_rx, e_tx} = {2{n / (DIV + 1) / (c[4] ? 16 : 1)}};
                default: ;
            endcase
            if (c[6])
                {e_rx, e_tx} = {etm_count(i_serial_line_model.rx_s),
                                etm_count(i_serial_line_model.tx_s)};
            e_tm = (c[2:0] == 3'h1 || c[2:0] == 3'h4) ? n : e_tx;
            if (e_rx >= 0) check(rx_cnt, e_rx);
            check(tx_cnt, e_tx);
            check(tm_cnt, e_tm);
            check(o_tx_clock_pin_oe_n, !(c[5] && c[3:0] != 4'h0));
            if (c == 8'h28) check(tg_cnt, e_tx);
            // Last vote window: samples at bits 55 to 57 of the burst
            vote = i_serial_line_model.d_s[55] + i_serial_line_model.d_s[56]
                   + i_serial_line_model.d_s[57];
            if (c == 8'h10) check(o_rx_bit, vote >= 2);
            else if (c != 8'h1b) check(o_rx_bit, rx_data);
        end
        for (int k = 0; k < 8; k++) begin
            @(posedge i_mclk);
            i_tx_slot_window <= 1'($urandom);
            fsync <= 1'($urandom);
            repeat (3) @(posedge i_mclk);
            @(negedge i_mclk);
            check(o_tx_clock_pin, !i_tx_slot_window);
            check(o_rx_sync, fsync);
            check(o_tx_sync, fsync);
        end
        give_verdict();
    end
endmodule // tb_top
